// [logic/rioc_clkout.sv]
// Host clock output generator
// Assumes xtal_tick pulses at 2x 13.56 MHz and lf_tick at 2x 32 kHz,
// both on ref_clk, from the oscillator logic outside
`include "rioc_defs.svh"
module rioc_clkout
   import rioc_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rstn,
   input wire logic xtal_running,
   input wire logic xtal_tick,
   input wire logic lf_tick,
   input wire logic [1:0] clk_sel,
   input wire logic slow_clock_suppress,
   output logic host_clock
);
   logic [2:0] div_cnt;
   logic [2:0] div_lim;

   always_comb
   begin
      case (rioc_clk_sel_t'(clk_sel))
         RIOC_CLK_339: div_lim = `RIOC_DIV_339;
         RIOC_CLK_678: div_lim = `RIOC_DIV_678;
         default: div_lim = `RIOC_DIV_1356;
      endcase
   end

   always_ff @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
         div_cnt <= 3'h0;
      else if (xtal_tick)
         div_cnt <= (div_cnt >= div_lim) ? 3'h0 : div_cnt + 3'h1;
   end

   always_ff @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
         host_clock <= 1'b0;
      else if (clk_sel == RIOC_CLK_OFF)
         host_clock <= 1'b0;
      else if (xtal_running)
      begin
         if (xtal_tick && div_cnt >= div_lim)
            host_clock <= ~host_clock;
      end
      else if (slow_clock_suppress)
         host_clock <= 1'b0;
      else if (lf_tick)
         host_clock <= ~host_clock;
   end
endmodule

// [logic/rioc_defs.svh]
// Register offsets, field positions, reset values, timing counts
// Included by every design file of the IO and operation control bank except the package
`ifndef RIOC_DEFS_SVH
`define RIOC_DEFS_SVH

`define RIOC_ADDR_IO1 6'h00
`define RIOC_ADDR_IO2 6'h01
`define RIOC_ADDR_OPC 6'h02

// Writable bit masks; other bits read zero
`define RIOC_MASK_IO1 8'hff
`define RIOC_MASK_IO2 8'hdd
`define RIOC_MASK_OPC 8'hfc

`define RIOC_RST_IO1 8'h08
`define RIOC_RST_IO2 8'h00
`define RIOC_RST_OPC 8'h00

`define RIOC_B_SINGLE 7
`define RIOC_B_PAIR 6
`define RIOC_B_RXLVL 5
`define RIOC_B_TXLVL 4
`define RIOC_B_XTAL 3
`define RIOC_B_CLKHI 2
`define RIOC_B_CLKLO 1
`define RIOC_B_SLOWOFF 0

`define RIOC_B_SUP3 7
`define RIOC_B_VREGOFF 6
`define RIOC_B_PDSEL 4
`define RIOC_B_PDDESEL 3
`define RIOC_B_IO18 2
`define RIOC_B_SLOWUP 0

`define RIOC_B_EN 7
`define RIOC_B_RXEN 6
`define RIOC_B_RXCHN 5
`define RIOC_B_RXMAN 4
`define RIOC_B_TXEN 3
`define RIOC_B_WU 2

`define RIOC_RX_LVL_LO 7'd64
`define RIOC_RX_LVL_HI 7'd80
`define RIOC_TX_LVL_LO 7'd32
`define RIOC_TX_LVL_HI 7'd16

// Slow ramp time in ns and cycles at 100 ns period (least time, rounded up)
`define RIOC_CLK_NS 100
`define RIOC_RAMP_NS 10000
`define RIOC_RAMP_CYC ((`RIOC_RAMP_NS + `RIOC_CLK_NS - 1) / `RIOC_CLK_NS)

// Clock output dividers of the 13.56 MHz reference (xtal_tick counts per half period, less one)
`define RIOC_DIV_339 3'd3
`define RIOC_DIV_678 3'd1
`define RIOC_DIV_1356 3'd0

`endif

// [logic/rioc_pkg.sv]
// Types shared by the IO and operation control bank
// Assumes nothing beyond a SystemVerilog compiler
package rioc_pkg;
   typedef enum logic [1:0]
   {
      RIOC_CLK_339 = 2'b00,
      RIOC_CLK_678 = 2'b01,
      RIOC_CLK_1356 = 2'b10,
      RIOC_CLK_OFF = 2'b11
   } rioc_clk_sel_t;

   typedef enum logic [1:0]
   {
      RIOC_RAMP_IDLE = 2'b00,
      RIOC_RAMP_RUN = 2'b01,
      RIOC_RAMP_ON = 2'b10
   } rioc_ramp_t;
endpackage

// [logic/rioc_ramp.sv]
// Transmitter turn-on ramp control
// Assumes tx_on is a level on ref_clk; level out 0..255 to the driver
`include "rioc_defs.svh"
module rioc_ramp
   import rioc_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rstn,
   input wire logic tx_on,
   input wire logic slow,
   output logic [7:0] level
);
   localparam int STEP_CYC = (`RIOC_RAMP_CYC + 254) / 255;
   rioc_ramp_t state;
   logic [7:0] step_cnt;

   always_ff @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         state <= RIOC_RAMP_IDLE;
         level <= 8'h00;
         step_cnt <= 8'h00;
      end
      else
      begin
         case (state)
            RIOC_RAMP_IDLE:
               if (tx_on)
               begin
                  if (slow)
                     state <= RIOC_RAMP_RUN;
                  else
                  begin
                     state <= RIOC_RAMP_ON;
                     level <= 8'hff;
                  end
               end
            RIOC_RAMP_RUN:
               if (!tx_on)
               begin
                  state <= RIOC_RAMP_IDLE;
                  level <= 8'h00;
               end
               else if (step_cnt >= 8'(STEP_CYC - 1))
               begin
                  // Linear steps of STEP_CYC cycles: 0 to 255 takes at least the full time
                  step_cnt <= 8'h00;
                  level <= level + 8'h01;
                  if (level == 8'hfe)
                     state <= RIOC_RAMP_ON;
               end
               else
                  step_cnt <= step_cnt + 8'h01;
            RIOC_RAMP_ON:
               if (!tx_on)
               begin
                  state <= RIOC_RAMP_IDLE;
                  level <= 8'h00;
               end
            default:
               state <= RIOC_RAMP_IDLE;
         endcase
      end
   end
endmodule

// [logic/rioc_regs.sv]
// IO configuration and operation control register bank
// Assumes an SPI engine decodes frames and presents one-cycle strobes on
// ref_clk; ss_n and miso enable come from the pins/SPI engine.
`include "rioc_defs.svh"
module rioc_regs
   import rioc_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rstn,
   input wire logic wr_stb,
   input wire logic [5:0] wr_addr,
   input wire logic [7:0] wr_data,
   input wire logic [5:0] rd_addr,
   output logic [7:0] rd_data,
   input wire logic field_on_cmd,
   input wire logic active_tx_done,
   input wire logic receiver_channel_pick,
   input wire logic ss_n_pin,
   input wire logic miso_drive_en,
   input wire logic xtal_running,
   input wire logic xtal_tick,
   input wire logic lf_tick,
   output logic single_driver,
   output logic driver_pair_select,
   output logic antenna_driver_one_en,
   output logic antenna_driver_two_en,
   output logic antenna_input_one_en,
   output logic antenna_input_two_en,
   output logic [6:0] rx_water_level,
   output logic [6:0] tx_water_level,
   output logic xtal_27m,
   output logic host_clock,
   output logic supply_mode_select,
   output logic digital_supply_rail_off,
   output logic miso_pulldown,
   output logic miso_strong_drive,
   output logic [7:0] tx_ramp_level,
   output logic osc_reg_enable,
   output logic rx_enable,
   output logic am_channel_en,
   output logic pm_channel_en,
   output logic auto_channel_sel,
   output logic tx_enable,
   output logic wakeup_enable
);
   logic [7:0] io_config_one;
   logic [7:0] io_config_two;
   logic [7:0] operation_control;
   logic ss_n_meta;
   logic ss_n_sync;
   logic slow_clock_suppress;
   logic [7:0] ramp_level;
   logic host_clock_raw;

   function automatic logic hit(input logic [5:0] a, input logic [5:0] r);
      hit = (a == r);
   endfunction

   // Reset is power-on only: no soft default command reaches here
   always_ff @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         io_config_one <= `RIOC_RST_IO1;
         io_config_two <= `RIOC_RST_IO2;
      end
      else if (wr_stb)
      begin
         if (hit(wr_addr, `RIOC_ADDR_IO1))
            io_config_one <= wr_data & `RIOC_MASK_IO1;
         if (hit(wr_addr, `RIOC_ADDR_IO2))
            io_config_two <= wr_data & `RIOC_MASK_IO2;
      end
   end

   always_ff @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
         operation_control <= `RIOC_RST_OPC;
      else
      begin
         if (wr_stb && hit(wr_addr, `RIOC_ADDR_OPC))
            operation_control <= wr_data & `RIOC_MASK_OPC;
         // Hardware set wins over a clearing write in the same cycle
         if (field_on_cmd)
            operation_control[`RIOC_B_TXEN] <= 1'b1;
         else if (active_tx_done)
            operation_control[`RIOC_B_TXEN] <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
         rd_data <= 8'h00;
      else if (hit(rd_addr, `RIOC_ADDR_IO1))
         rd_data <= io_config_one;
      else if (hit(rd_addr, `RIOC_ADDR_IO2))
         rd_data <= io_config_two;
      else if (hit(rd_addr, `RIOC_ADDR_OPC))
         rd_data <= operation_control;
      else
         rd_data <= 8'h00;
   end

   // Slave select is a pin: two flops before use
   always_ff @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         ss_n_meta <= 1'b1;
         ss_n_sync <= 1'b1;
      end
      else
      begin
         ss_n_meta <= ss_n_pin;
         ss_n_sync <= ss_n_meta;
      end
   end

   always_ff @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         single_driver <= 1'b0;
         driver_pair_select <= 1'b0;
         antenna_driver_one_en <= 1'b0;
         antenna_driver_two_en <= 1'b0;
         antenna_input_one_en <= 1'b0;
         antenna_input_two_en <= 1'b0;
      end
      else
      begin
         single_driver <= io_config_one[`RIOC_B_SINGLE];
         driver_pair_select <= io_config_one[`RIOC_B_PAIR];
         antenna_driver_one_en <= !io_config_one[`RIOC_B_SINGLE] ||
            !io_config_one[`RIOC_B_PAIR];
         antenna_driver_two_en <= !io_config_one[`RIOC_B_SINGLE] ||
            io_config_one[`RIOC_B_PAIR];
         antenna_input_one_en <= !io_config_one[`RIOC_B_SINGLE] ||
            !io_config_one[`RIOC_B_PAIR];
         antenna_input_two_en <= !io_config_one[`RIOC_B_SINGLE] ||
            io_config_one[`RIOC_B_PAIR];
      end
   end

   always_ff @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         rx_water_level <= `RIOC_RX_LVL_LO;
         tx_water_level <= `RIOC_TX_LVL_LO;
         xtal_27m <= 1'b1;
      end
      else
      begin
         rx_water_level <= io_config_one[`RIOC_B_RXLVL] ?
            `RIOC_RX_LVL_HI : `RIOC_RX_LVL_LO;
         tx_water_level <= io_config_one[`RIOC_B_TXLVL] ?
            `RIOC_TX_LVL_HI : `RIOC_TX_LVL_LO;
         xtal_27m <= io_config_one[`RIOC_B_XTAL];
      end
   end

   always_ff @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         supply_mode_select <= 1'b0;
         digital_supply_rail_off <= 1'b0;
         miso_pulldown <= 1'b0;
         miso_strong_drive <= 1'b0;
      end
      else
      begin
         supply_mode_select <= io_config_two[`RIOC_B_SUP3];
         digital_supply_rail_off <= io_config_two[`RIOC_B_VREGOFF];
         // miso_drive_en is same-domain SPI logic, no sync needed
         miso_pulldown <= (io_config_two[`RIOC_B_PDSEL] && !ss_n_sync &&
            !miso_drive_en) ||
            (io_config_two[`RIOC_B_PDDESEL] && ss_n_sync);
         miso_strong_drive <= io_config_two[`RIOC_B_IO18];
      end
   end

   always_ff @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         osc_reg_enable <= 1'b0;
         rx_enable <= 1'b0;
         am_channel_en <= 1'b0;
         pm_channel_en <= 1'b0;
         auto_channel_sel <= 1'b0;
         tx_enable <= 1'b0;
         wakeup_enable <= 1'b0;
      end
      else
      begin
         osc_reg_enable <= operation_control[`RIOC_B_EN];
         rx_enable <= operation_control[`RIOC_B_RXEN];
         am_channel_en <= !operation_control[`RIOC_B_RXCHN] ||
            !receiver_channel_pick;
         pm_channel_en <= !operation_control[`RIOC_B_RXCHN] ||
            receiver_channel_pick;
         auto_channel_sel <= !operation_control[`RIOC_B_RXCHN] &&
            !operation_control[`RIOC_B_RXMAN];
         tx_enable <= operation_control[`RIOC_B_TXEN];
         wakeup_enable <= operation_control[`RIOC_B_WU];
      end
   end

   assign slow_clock_suppress = io_config_one[`RIOC_B_SLOWOFF];

   rioc_clkout u_clkout
   (
      .ref_clk(ref_clk),
      .rstn(rstn),
      .xtal_running(xtal_running),
      .xtal_tick(xtal_tick),
      .lf_tick(lf_tick),
      .clk_sel(io_config_one[`RIOC_B_CLKHI:`RIOC_B_CLKLO]),
      .slow_clock_suppress(slow_clock_suppress),
      .host_clock(host_clock_raw)
   );

   rioc_ramp u_ramp
   (
      .ref_clk(ref_clk),
      .rstn(rstn),
      .tx_on(operation_control[`RIOC_B_TXEN]),
      .slow(io_config_two[`RIOC_B_SLOWUP]),
      .level(ramp_level)
   );

   // Both sub outputs already come from flops; held one more for uniformity
   always_ff @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         host_clock <= 1'b0;
         tx_ramp_level <= 8'h00;
      end
      else
      begin
         host_clock <= host_clock_raw;
         tx_ramp_level <= ramp_level;
      end
   end
endmodule

// [verif/rioc_host.sv]
// Host side model: SPI engine write strobes and slave-select pins
// Tasks are entered 10 ns after a rising edge of ref_clk
module rioc_host
(
   input wire logic ref_clk,
   output logic wr_stb,
   output logic [5:0] wr_addr,
   output logic [7:0] wr_data,
   output logic ss_n_pin,
   output logic miso_drive_en
);
   timeunit 1ns;
   timeprecision 1ns;
   initial
   begin
      wr_stb = 1'b0;
      wr_addr = 6'h00;
      wr_data = 8'h00;
      ss_n_pin = 1'b1;
      miso_drive_en = 1'b0;
   end
   task automatic write(input logic [5:0] a, input logic [7:0] d);
      wr_addr = a;
      wr_data = d;
      wr_stb = 1'b1;
      @(posedge ref_clk);
      #10;
   endtask
   // Released bus shows the inverse, never the last value
   task automatic idle();
      wr_stb = 1'b0;
      wr_addr = ~wr_addr;
      wr_data = ~wr_data;
      @(posedge ref_clk);
      #10;
   endtask
   task automatic pins(input logic ss, input logic drv);
      ss_n_pin = ss;
      miso_drive_en = drv;
   endtask
endmodule

// [verif/rioc_regs_chk.sv]
// Port assertions for the IO and operation control bank
// Bound to rioc_regs; sees its ports only, one clock domain
module rioc_regs_chk
(
   input wire logic ref_clk,
   input wire logic rstn,
   input wire logic wr_stb,
   input wire logic [5:0] wr_addr,
   input wire logic [7:0] wr_data,
   input wire logic [5:0] rd_addr,
   input wire logic [7:0] rd_data,
   input wire logic field_on_cmd,
   input wire logic active_tx_done,
   input wire logic single_driver,
   input wire logic antenna_driver_one_en,
   input wire logic antenna_driver_two_en,
   input wire logic [6:0] rx_water_level,
   input wire logic [6:0] tx_water_level,
   input wire logic xtal_27m,
   input wire logic host_clock,
   input wire logic am_channel_en,
   input wire logic pm_channel_en,
   input wire logic auto_channel_sel,
   input wire logic tx_enable
);
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rstn);
   // Write data two edges back, when derived outputs show it
   logic [7:0] d1;
   logic [7:0] d2;
   always_ff @(posedge ref_clk)
   begin
      d1 <= wr_data;
      d2 <= d1;
   end
   sequence w0;
      wr_stb && wr_addr == 6'h00;
   endsequence
   sequence w2;
      wr_stb && wr_addr == 6'h02;
   endsequence
   sequence clk_off_held;
      (w0 ##0 wr_data[2:1] == 2'b11) ##1 (!(wr_stb && wr_addr == 6'h00))[*6];
   endsequence
   rx_level_a: assert property (w0 |=> ##1
      rx_water_level == (d2[5] ? 7'd80 : 7'd64)) else $error("rx level");
   tx_level_a: assert property (w0 |=> ##1
      tx_water_level == (d2[4] ? 7'd16 : 7'd32)) else $error("tx level");
   xtal_sel_a: assert property (w0 |=> ##1 xtal_27m == d2[3])
      else $error("xtal select");
   antenna_sel_a: assert property (w0 |=> ##1
      {single_driver, antenna_driver_one_en, antenna_driver_two_en} ==
      {d2[7], !d2[7] || !d2[6], !d2[7] || d2[6]}) else $error("antenna");
   chan_count_a: assert property (w2 |=> ##1
      {am_channel_en && pm_channel_en, am_channel_en ^ pm_channel_en} ==
      {!d2[5], d2[5]}) else $error("channel count");
   chan_auto_a: assert property ((w2 ##0 !wr_data[5]) |=> ##1
      auto_channel_sel == !d2[4]) else $error("channel auto");
   field_on_a: assert property (field_on_cmd |=> ##1 tx_enable)
      else $error("field on");
   tx_done_a: assert property (active_tx_done && !field_on_cmd
      |=> ##1 !tx_enable) else $error("tx done");
   unmapped_a: assert property (rd_addr > 6'h02 |=> rd_data == 8'h00)
      else $error("unmapped read");
   clk_off_a: assert property (clk_off_held |-> !host_clock)
      else $error("clock off");
endmodule
bind rioc_regs rioc_regs_chk u_chk (.ref_clk, .rstn, .wr_stb, .wr_addr,
   .wr_data, .rd_addr, .rd_data, .field_on_cmd, .active_tx_done,
   .single_driver, .antenna_driver_one_en, .antenna_driver_two_en,
   .rx_water_level, .tx_water_level, .xtal_27m, .host_clock,
   .am_channel_en, .pm_channel_en, .auto_channel_sel, .tx_enable);

// [verif/rioc_regs_tb_top.sv]
// Self-checking bench of the IO and operation control bank
// Drives rioc_regs through rioc_host; oscillator ticks from the bench
`include "rioc_defs.svh"
module rioc_regs_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct {logic [2:0] sel; logic [7:0] exp;} rioc_note_t;
   logic ref_clk = 1'b0;
   logic rstn, field_on_cmd, active_tx_done, receiver_channel_pick;
   logic xtal_running, xtal_tick, lf_tick, wr_stb, ss_n_pin, miso_drive_en;
   logic [5:0] rd_addr, wr_addr, a;
   logic [7:0] wr_data, rd_data, tx_ramp_level, io1, io2, opc, d, meas;
   logic [6:0] rx_water_level, tx_water_level;
   logic single_driver, driver_pair_select, antenna_driver_one_en;
   logic antenna_driver_two_en, antenna_input_one_en, antenna_input_two_en;
   logic xtal_27m, host_clock, supply_mode_select, digital_supply_rail_off;
   logic miso_pulldown, miso_strong_drive, osc_reg_enable, rx_enable;
   logic am_channel_en, pm_channel_en, auto_channel_sel, tx_enable;
   logic wakeup_enable;
   int err_count = 0;
   int n_compared = 0;
   int k, t;
   integer seed;
   rioc_note_t notes [$];
   rioc_note_t cur;
   string nm [0:7] = '{"rd_data", "rx_lvl_xtal", "tx_lvl_single",
      "drive_supply", "opctl_pd", "ramp_level", "clk_toggles", "ramp_slow"};
   logic [5:0] adr [4] = '{6'h00, 6'h01, 6'h02, 6'h2a};
   logic [9:0] pdt [5] = '{10'h040, 10'h041, 10'h042, 10'h022, 10'h020};
   logic [7:0] cfg [6] = '{8'h08, 8'h0a, 8'h0c, 8'h0e, 8'h08, 8'h09};
   logic [7:0] tog [6] = '{8'd16, 8'd32, 8'd64, 8'd0, 8'd64, 8'd0};
   rioc_regs u_dut (.*);
   rioc_host u_host (.*);
   always #50 ref_clk = ~ref_clk;
   function automatic logic [7:0] pick(input logic [2:0] s);
      case (s)
         3'd0: pick = rd_data;
         3'd1: pick = {rx_water_level, xtal_27m};
         3'd2: pick = {tx_water_level, single_driver};
         3'd3: pick = {driver_pair_select, antenna_driver_one_en,
            antenna_driver_two_en, antenna_input_one_en, antenna_input_two_en,
            supply_mode_select, digital_supply_rail_off, miso_strong_drive};
         3'd4: pick = {osc_reg_enable, rx_enable, am_channel_en, pm_channel_en,
            auto_channel_sel, tx_enable, wakeup_enable, miso_pulldown};
         3'd5: pick = tx_ramp_level;
         default: pick = meas;
      endcase
   endfunction
   task automatic cmp(input logic [2:0] s, input logic [7:0] e);
      n_compared++;
      if (pick(s) !== e)
      begin
         err_count++;
         $display("BAD %s exp %h seen %h", nm[s], e, pick(s));
      end
   endtask
   // Outputs settle before the falling edge, so compare there
   always @(negedge ref_clk)
      while (notes.size() > 0)
      begin
         cur = notes.pop_front();
         cmp(cur.sel, cur.exp);
      end
   task automatic look(input logic [2:0] s, input logic [7:0] e);
      notes.push_back('{s, e});
      @(posedge ref_clk);
      #10;
   endtask
   task automatic summarize();
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task automatic guard(input int n);
      if (n >= 1000)
      begin
         err_count++;
         summarize();
      end
   endtask
   task automatic wr(input logic [5:0] wa, input logic [7:0] wd);
      u_host.write(wa, wd);
      u_host.idle();
      if (wa == 6'h00) io1 = wd;
      if (wa == 6'h01) io2 = wd & `RIOC_MASK_IO2;
      if (wa == 6'h02) opc = wd & `RIOC_MASK_OPC;
   endtask
   task automatic rd(input logic [5:0] ra, input logic [7:0] e);
      rd_addr = ra;
      @(posedge ref_clk);
      #10;
      look(3'd0, e);
   endtask
   task automatic rd_all();
      rd(6'h00, io1);
      rd(6'h01, io2);
      rd(6'h02, opc);
      rd(6'h3f, 8'h00);
   endtask
   task automatic outs();
      logic pd;
      logic [2:0] ch;
      pd = (io2[3] && ss_n_pin) || (io2[4] && !ss_n_pin && !miso_drive_en);
      // One channel by the pick input, else both with auto unless manual
      ch = opc[5] ? {!receiver_channel_pick, receiver_channel_pick, 1'b0} :
         {2'b11, !opc[4]};
      look(3'd1, {io1[5] ? 7'd80 : 7'd64, io1[3]});
      look(3'd2, {io1[4] ? 7'd16 : 7'd32, io1[7]});
      look(3'd3, {io1[6], !io1[7] || !io1[6], !io1[7] || io1[6],
         !io1[7] || !io1[6], !io1[7] || io1[6],
         io2[7], io2[6], io2[2]});
      look(3'd4, {opc[7], opc[6], ch,
         opc[3], opc[2], pd});
   endtask
   task automatic pulse(input logic on, input logic off);
      field_on_cmd = on;
      active_tx_done = off;
      // Set beats clear when both strobes meet
      if (on || off) opc[3] = on;
      @(posedge ref_clk);
      #10;
      field_on_cmd = 1'b0;
      active_tx_done = 1'b0;
   endtask
   task automatic count_clk();
      logic prev;
      meas = 8'h00;
      repeat (8) @(posedge ref_clk);
      #10;
      prev = host_clock;
      repeat (64)
      begin
         @(posedge ref_clk);
         #10;
         if (host_clock !== prev) meas++;
         prev = host_clock;
      end
   endtask
   initial
   begin
      seed = 32'h4d8b8977;
      {rstn, field_on_cmd, active_tx_done, receiver_channel_pick} = 4'h0;
      {xtal_running, xtal_tick, lf_tick, rd_addr} = 9'h000;
      {io1, io2, opc} = {`RIOC_RST_IO1, `RIOC_RST_IO2, `RIOC_RST_OPC};
      repeat (5) @(posedge ref_clk);
      #10;
      rstn = 1'b1;
      rd_all();
      outs();
      $display("reset test done");
      for (k = 0; k < 12; k++)
      begin
         d = 8'($random(seed));
         a = adr[k % 4];
         if (a == 6'h02) d[5] = 1'b0;
         wr(a, d);
         rd_all();
         outs();
      end
      u_host.write(6'h00, 8'h35);
      u_host.write(6'h00, 8'hf0);
      u_host.idle();
      io1 = 8'hf0;
      outs();
      rstn = 1'b0;
      @(posedge ref_clk);
      #10;
      rstn = 1'b1;
      {io1, io2, opc} = {`RIOC_RST_IO1, `RIOC_RST_IO2, `RIOC_RST_OPC};
      rd_all();
      $display("write test done");
      wr(6'h02, 8'h80);
      pulse(1'b1, 1'b0);
      rd(6'h02, 8'h88);
      pulse(1'b0, 1'b1);
      rd(6'h02, 8'h80);
      pulse(1'b1, 1'b1);
      rd(6'h02, 8'h88);
      active_tx_done = 1'b1;
      u_host.write(6'h02, 8'h88);
      active_tx_done = 1'b0;
      u_host.idle();
      rd(6'h02, 8'h80);
      pulse(1'b1, 1'b0);
      repeat (3) @(posedge ref_clk);
      #10;
      look(3'd5, 8'hff);
      pulse(1'b0, 1'b1);
      wr(6'h01, 8'h01);
      for (k = 0; k < 1000 && tx_ramp_level !== 8'h00; k++)
      begin
         @(posedge ref_clk);
         #10;
      end
      guard(k);
      pulse(1'b1, 1'b0);
      t = 0;
      for (k = 0; k < 1000 && tx_ramp_level !== 8'hff; k++)
      begin
         @(posedge ref_clk);
         #10;
         if (tx_ramp_level > 8'd25 && tx_ramp_level < 8'd230) t++;
      end
      guard(k);
      meas = (t >= 100) ? 8'h01 : 8'h00;
      look(3'd7, 8'h01);
      $display("transmit test done");
      for (k = 0; k < 5; k++)
      begin
         wr(6'h01, pdt[k][9:2]);
         u_host.pins(pdt[k][1], pdt[k][0]);
         repeat (4) @(posedge ref_clk);
         #10;
         outs();
      end
      wr(6'h02, 8'h40);
      outs();
      wr(6'h02, 8'h50);
      outs();
      wr(6'h02, 8'h60);
      receiver_channel_pick = 1'b1;
      repeat (3) @(posedge ref_clk);
      #10;
      outs();
      receiver_channel_pick = 1'b0;
      outs();
      $display("pin and channel test done");
      {xtal_running, xtal_tick, lf_tick} = 3'b111;
      for (k = 0; k < 6; k++)
      begin
         if (k == 4) xtal_running = 1'b0;
         wr(6'h00, cfg[k]);
         count_clk();
         look(3'd6, tog[k]);
      end
      $display("clock test done");
      summarize();
   end
endmodule
